// *** common/lb_pkg.sv ***
// Purpose: Constants and carrier types for the line loopback and test pattern block
// Assumes: 50 MHz system clock, all line-side clocks sampled as plain inputs
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
package lb_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_CLEAR = 4'h8;
  // Control field positions
  localparam int CTL_LOCAL = 0;
  localparam int CTL_REMOTE = 1;
  localparam int CTL_ANALOG = 2;
  localparam int CTL_NETDET = 3;
  localparam int CTL_ALLONES = 4;
  localparam int CTL_PATLOW = 5;
  localparam int CTL_PATHIGH = 6;
  localparam int CTL_E1 = 7;
  localparam int CTL_UNIPOLAR = 8;
  localparam int CTL_DECODERS = 9;
  localparam int CTL_JITTER = 10;
  localparam int CTL_WIDTH = 11;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 11'h000;
  // Status field positions
  localparam int ST_SYNC = 0;
  localparam int ST_SYNCCHG = 1;
  localparam int ST_NETLOOP = 2;
  localparam int ST_INT = 3;
  // Timing
  localparam longint SYS_HZ = 50_000_000;
  localparam longint LOOP_CODE_MS = 5000;
  localparam longint LOOP_CODE_CYCLES = (SYS_HZ / 1000) * LOOP_CODE_MS;
  localparam int CLK_ABSENT_NS = 2000;
  localparam int CLK_ABSENT_CYCLES = CLK_ABSENT_NS / 20;
  localparam int MCLK_DIV = 32;
  // Pattern generator constants
  localparam int MAX_ZEROS = 14;
  localparam int SYNC_WINDOW = 128;
  localparam int SYNC_ERRORS = 4;
  localparam logic [19:0] PRBS_SEED = 20'hFFFFF;
  localparam logic [4:0] CODE_UP = 5'h01;
  localparam logic [4:0] CODE_DOWN = 5'h01;
  localparam int CODE_UP_LEN = 5;
  localparam int CODE_DOWN_LEN = 3;
  // Pattern select encodings {high, low}
  localparam logic [1:0] PAT_OFF = 2'h0;
  localparam logic [1:0] PAT_UP = 2'h1;
  localparam logic [1:0] PAT_PRBS = 2'h2;
  localparam logic [1:0] PAT_DOWN = 2'h3;
  // Rail pair carrier
  typedef struct packed {
    logic pos;
    logic neg;
  } rail_s;
  // Network loop detector states
  typedef enum logic [1:0] {
    NET_IDLE = 2'b00,
    NET_ACTIVE = 2'b01
  } net_e;
endpackage

// *** rtl/line_loopback_and_test_patterns.sv ***
// Purpose: Loopback steering, test pattern generation, error insertion and checks
// Assumes: transmit and recovered clocks arrive as pins and are edge-detected on sys_clk
// Notes: Jitter attenuator, encoders and the line analog path are outside this block
`timescale 1ns/1ps
module line_loopback_and_test_patterns
  import lb_pkg::*;
#(
  parameter longint LOOP_CODE_LIMIT = LOOP_CODE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic transmit_clock,
  input wire logic master_clock,
  input wire rail_s transmit_rail_inputs,
  input wire logic recovered_clock,
  input wire rail_s line_receiver_inputs,
  input wire logic logic_error_insert_pin,
  input wire logic violation_insert_pin,
  output rail_s line_driver_outputs,
  output logic line_clock_out,
  output rail_s receive_rail_outputs,
  output logic receive_clock_out,
  output logic violation_flag_pin,
  output logic jitter_in_loop,
  output logic prbs_interrupt_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, two flops on every outside signal
  logic [8:0] syncA; // First stage, read only by syncB
  logic [8:0] syncB; // Second stage
  logic [8:0] syncC; // Delayed copy for edge finding
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else begin
      syncA <= {violation_insert_pin, logic_error_insert_pin, line_receiver_inputs,
                recovered_clock, transmit_rail_inputs, master_clock, transmit_clock};
      syncB <= syncA;
      syncC <= syncB;
    end
  end
  wire txClkS = syncB[0];
  wire txFall = !syncB[0] && syncC[0];
  wire txRise = syncB[0] && !syncC[0];
  wire mRise = syncB[1] && !syncC[1];
  rail_s txRail;
  assign txRail = syncB[3:2];
  wire rxPinRise = syncB[4] && !syncC[4];
  rail_s rxPin; // Synchronised line receiver inputs
  assign rxPin = syncB[6:5];
  wire errEdge = syncB[7] && !syncC[7];
  wire bpvEdge = syncB[8] && !syncC[8];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave, single wait state on reads
  logic [CTL_WIDTH-1:0] control; // Software control bits
  logic readPending; // Read answered next cycle
  logic syncState, syncChanged, clearMask;
  net_e netState;
  wire wrCtl = avs_write && avs_address == OFS_CONTROL;
  wire wrClr = avs_write && avs_address == OFS_CLEAR;
  assign avs_waitrequest = avs_read && !readPending;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      control <= CTL_RESET;
      clearMask <= 1'b0;
    end else begin
      if (wrCtl) begin
        control <= avs_writedata[CTL_WIDTH-1:0];
      end
      if (wrClr) begin
        clearMask <= avs_writedata[ST_SYNCCHG];
      end
    end
  end
  // Read data register; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      readPending <= 1'b0;
      avs_readdata <= '0;
    end else begin
      readPending <= avs_read && !readPending;
      avs_readdata <= '0;
      if (avs_read && !readPending) begin
        unique case (avs_address)
          OFS_CONTROL: avs_readdata <= {21'h0, control};
          OFS_STATUS: avs_readdata <= {28'h0, !prbs_interrupt_n, netState == NET_ACTIVE,
                                       syncChanged, syncState};
          OFS_CLEAR: avs_readdata <= {30'h0, clearMask, 1'b0};
          default: avs_readdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding
  wire analogOn = control[CTL_ANALOG];
  wire remoteOn = control[CTL_REMOTE] && !analogOn;
  wire localOn = control[CTL_LOCAL] && !analogOn;
  wire netOn = netState == NET_ACTIVE;
  wire retransmit = remoteOn || netOn;
  wire dualOn = retransmit && localOn;
  wire [1:0] patSel = {control[CTL_PATHIGH], control[CTL_PATLOW]};
  wire prbsOn = patSel == PAT_PRBS;
  wire codeOn = patSel == PAT_UP || patSel == PAT_DOWN;
  wire onesOn = control[CTL_ALLONES] && !retransmit;
  wire e1Mode = control[CTL_E1];
  assign jitter_in_loop = localOn && control[CTL_JITTER];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit clock watchdog; master clock stands in when it stops
  logic [7:0] txIdle; // Cycles since last rising transmit edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txIdle <= '0;
    end else if (txRise) begin
      txIdle <= '0;
    end else if (txIdle != 8'(CLK_ABSENT_CYCLES)) begin
      txIdle <= txIdle + 8'h01;
    end
  end
  wire txAbsent = txIdle == 8'(CLK_ABSENT_CYCLES);
  wire bitTick = txAbsent ? mRise : txFall;
  // Analog loop: receiver sees our own line outputs once they stand
  logic tickDly; // Bit strobe delayed by one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tickDly <= 1'b0;
    end else begin
      tickDly <= bitTick;
    end
  end
  rail_s rxLine; // Receive data seen by the detectors
  assign rxLine = analogOn ? line_driver_outputs : rxPin;
  wire rxRise = analogOn ? tickDly : rxPinRise;

  ////////////////////////////////////////////////////////////////////////////
  // Pending error requests, held until the next usable bit
  logic errPend, bpvPend; // Requests waiting for a bit slot
  logic jammed; // Current bit is forced to one
  logic [19:0] prbs; // Shift register of the quasi-random source
  logic [3:0] zeroRun; // Zeros sent in a row
  logic [2:0] codePos; // Loop code bit position
  logic genBit; // Raw generated bit
  logic txBit; // Bit after errors
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      errPend <= 1'b0;
      bpvPend <= 1'b0;
    end else begin
      // Set wins over the consume of the same cycle
      if (errEdge) begin
        errPend <= 1'b1;
      end else if (bitTick && !jammed) begin
        errPend <= 1'b0;
      end
      if (bpvEdge) begin
        bpvPend <= 1'b1;
      end else if (bitTick && (txBit || onesOn)) begin
        bpvPend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quasi-random source and loop code generator
  wire prbsFb = e1Mode ? (prbs[14] ^ prbs[13]) : (prbs[19] ^ prbs[16]);
  wire prbsRaw = e1Mode ? !prbs[14] : prbs[19];
  assign jammed = !e1Mode && zeroRun >= 4'(MAX_ZEROS) && !prbsRaw;
  always_comb begin
    genBit = 1'b1;
    if (prbsOn) begin
      genBit = prbsRaw || jammed;
    end else if (patSel == PAT_UP) begin
      genBit = CODE_UP[3'(CODE_UP_LEN - 1) - codePos];
    end else if (patSel == PAT_DOWN) begin
      genBit = CODE_DOWN[3'(CODE_DOWN_LEN - 1) - codePos];
    end
    txBit = genBit ^ (errPend && !jammed && (prbsOn || codeOn));
  end
  always_ff @(posedge sys_clk) begin
    if (reset || !(prbsOn || codeOn)) begin
      prbs <= PRBS_SEED;
      zeroRun <= '0;
      codePos <= '0;
    end else if (bitTick) begin
      prbs <= {prbs[18:0], prbsFb};
      zeroRun <= txBit ? 4'h0 : (zeroRun == 4'hF ? zeroRun : zeroRun + 4'h1);
      if (codePos == 3'((patSel == PAT_UP ? CODE_UP_LEN : CODE_DOWN_LEN) - 1)) begin
        codePos <= '0;
      end else begin
        codePos <= codePos + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit and receive steering
  logic markPol; // Alternating mark polarity
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      line_driver_outputs <= '0;
      line_clock_out <= 1'b0;
      receive_rail_outputs <= '0;
      receive_clock_out <= 1'b0;
      markPol <= 1'b0;
    end else begin
      if (retransmit) begin
        line_driver_outputs <= rxLine;
        line_clock_out <= syncB[4];
      end else if (bitTick) begin
        line_clock_out <= !txAbsent || syncB[1];
        if (onesOn || prbsOn || codeOn) begin
          if (!(txBit || onesOn)) begin
            line_driver_outputs <= '0;
          end else if (bpvPend && !(onesOn && localOn)) begin
            // Violation repeats and keeps the last polarity, so only one mark breaks
            line_driver_outputs <= markPol ? 2'b10 : 2'b01;
          end else begin
            markPol <= !markPol;
            line_driver_outputs <= markPol ? 2'b01 : 2'b10;
          end
        end else begin
          line_driver_outputs <= txRail;
        end
      end else begin
        line_clock_out <= txAbsent ? syncB[1] : txClkS;
      end
      // Receive outputs
      if (analogOn) begin
        receive_rail_outputs <= line_driver_outputs;
        receive_clock_out <= line_clock_out;
      end else if (localOn) begin
        receive_rail_outputs <= (prbsOn || codeOn) ? {1'b0, txBit} : txRail;
        receive_clock_out <= txClkS;
      end else begin
        receive_rail_outputs <= rxLine;
        receive_clock_out <= syncB[4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received violation reporting
  logic lastMarkNeg, rxPrevMark;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      violation_flag_pin <= 1'b0;
      lastMarkNeg <= 1'b0;
      rxPrevMark <= 1'b0;
    end else begin
      violation_flag_pin <= 1'b0;
      if (rxRise && (rxLine.pos || rxLine.neg)) begin
        rxPrevMark <= 1'b1;
        lastMarkNeg <= rxLine.neg;
        if (rxPrevMark && lastMarkNeg == rxLine.neg
            && (!control[CTL_DECODERS] || control[CTL_UNIPOLAR])) begin
          violation_flag_pin <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive pattern detector with 128-bit error windows
  logic [19:0] rxShift; // Self-synchronising reference
  logic [6:0] winCount; // Bits in current window
  logic [7:0] winErr; // Errors in current window
  wire rxBit = rxLine.pos || rxLine.neg;
  wire rxData = e1Mode ? !rxBit : rxBit;
  wire rxExpect = e1Mode ? (rxShift[14] ^ rxShift[13]) : (rxShift[19] ^ rxShift[16]);
  always_ff @(posedge sys_clk) begin
    if (reset || !prbsOn) begin
      rxShift <= '0;
      winCount <= '0;
      winErr <= '0;
      syncState <= 1'b0;
    end else if (rxRise) begin
      rxShift <= {rxShift[18:0], rxData};
      winCount <= winCount + 7'h01;
      winErr <= winErr + 8'(rxExpect != rxData);
      if (winCount == 7'(SYNC_WINDOW - 1)) begin
        winErr <= '0;
        if (winErr < 8'(SYNC_ERRORS)) begin
          syncState <= 1'b1;
        end else if (winErr > 8'(SYNC_ERRORS)) begin
          syncState <= 1'b0;
        end
      end
    end
  end
  // Change flag: set wins over clear
  logic syncPrev;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      syncPrev <= 1'b0;
      syncChanged <= 1'b0;
    end else begin
      syncPrev <= syncState;
      if (syncPrev != syncState) begin
        syncChanged <= 1'b1;
      end else if (wrClr && avs_writedata[ST_SYNCCHG]) begin
        syncChanged <= 1'b0;
      end
    end
  end
  assign prbs_interrupt_n = !(syncChanged && !clearMask);

  ////////////////////////////////////////////////////////////////////////////
  // Network loop code detector, five-second persistence
  logic [4:0] codeHist; // Recent received bits
  logic [31:0] persist; // System cycles the code has held
  logic upSeen, downSeen;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      codeHist <= '0;
      upSeen <= 1'b0;
      downSeen <= 1'b0;
    end else if (rxRise) begin
      codeHist <= {codeHist[3:0], rxBit};
      upSeen <= {codeHist[3:0], rxBit} == CODE_UP || (upSeen && codeHist[4:0] != 5'h1F && rxBit == codeHist[4]);
      downSeen <= {codeHist[1:0], rxBit} == 3'h1 || (downSeen && rxBit == codeHist[2]);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset || !control[CTL_NETDET] || remoteOn || analogOn) begin
      netState <= NET_IDLE;
      persist <= '0;
    end else begin
      unique case (netState)
        NET_IDLE: begin
          persist <= upSeen ? persist + 32'h1 : 32'h0;
          if (persist >= 32'(LOOP_CODE_LIMIT)) begin
            netState <= NET_ACTIVE;
            persist <= '0;
          end
        end
        NET_ACTIVE: begin
          persist <= downSeen ? persist + 32'h1 : 32'h0;
          if (persist >= 32'(LOOP_CODE_LIMIT)) begin
            netState <= NET_IDLE;
            persist <= '0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_ANALOG_WINS: assert property (@(posedge sys_clk) disable iff (reset)
    analogOn |-> !retransmit && !localOn) else $error("analog loop did not override");
  AST_RETX: assert property (@(posedge sys_clk) disable iff (reset)
    retransmit |=> line_driver_outputs == $past(rxLine)) else $error("line not retransmitted");
  AST_NET_GATE: assert property (@(posedge sys_clk) disable iff (reset)
    !control[CTL_NETDET] |=> netState == NET_IDLE) else $error("network loop without detection");
  AST_ONES_SUPP: assert property (@(posedge sys_clk) disable iff (reset)
    control[CTL_REMOTE] && !analogOn |-> !onesOn) else $error("all-ones not suppressed");
  AST_JAM: assert property (@(posedge sys_clk) disable iff (reset)
    prbsOn && !e1Mode && zeroRun >= 4'(MAX_ZEROS) |-> genBit) else $error("zero run not jammed");
  AST_FLAG_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
    violation_flag_pin |=> !violation_flag_pin) else $error("violation flag too long");
  AST_SYNC_FLAG: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(syncState) |-> ##1 syncChanged) else $error("sync change not flagged");
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (reset)
    syncChanged && !clearMask |-> !prbs_interrupt_n) else $error("interrupt not raised");
endmodule

// *** verif/framer_line_model.sv ***
// Purpose: Framer and twisted-pair line stand-in for the loopback block
// Assumes: Bit clocks of 160 ns; marks go out as alternating rails
// Notes: Bit clocks stop while off; master clock runs free
`timescale 1ns/1ps
module framer_line_model
  import lb_pkg::*;
(
  input wire logic clkOn,
  input wire logic rxOn,
  input wire logic txMarks,
  input wire logic rxViolReq,
  input wire logic [4:0] rxPat,
  input wire logic [2:0] rxLen,
  output logic transmit_clock,
  output logic master_clock,
  output logic recovered_clock,
  output rail_s transmit_rail_inputs,
  output rail_s line_receiver_inputs
);
  logic txPol = 1'b0; // Polarity for the next transmit bit, flips every clock
  logic rxPol = 1'b0; // Polarity of last line mark
  logic violDone = 1'b0; // One violation per request
  int idx = 0; // Position in line pattern
  ////////////////////////////////////////////////////////////////
  // Clocks: bit clocks stand still while off, phase unrelated
  initial begin
    transmit_clock = 1'b0;
    forever #80 transmit_clock = clkOn & ~transmit_clock;
  end
  initial begin
    recovered_clock = 1'b0;
    #37;
    forever #80 recovered_clock = rxOn & ~recovered_clock;
  end
  initial begin
    master_clock = 1'b0;
    forever #81 master_clock = ~master_clock;
  end
  ////////////////////////////////////////////////////////////////
  // Framer launches one bit per rising transmit clock
  initial transmit_rail_inputs = 2'h0;
  always @(posedge transmit_clock) begin
    transmit_rail_inputs <= txMarks ? {txPol, ~txPol} : 2'h0;
    txPol <= ~txPol;
  end
  ////////////////////////////////////////////////////////////////
  // Line sends the pattern MSB first, repeated end to end
  initial line_receiver_inputs = 2'h0;
  always @(negedge rxOn) line_receiver_inputs <= 2'h0;
  always @(posedge recovered_clock) begin
    if (idx >= int'(rxLen)) idx = 0;
    if (!rxPat[int'(rxLen) - 1 - idx]) begin
      line_receiver_inputs <= 2'h0;
    end else if (rxViolReq && !violDone) begin
      // Repeat last polarity: a bipolar violation
      line_receiver_inputs <= {rxPol, ~rxPol};
      violDone <= 1'b1;
    end else begin
      line_receiver_inputs <= {~rxPol, rxPol};
      rxPol <= ~rxPol;
    end
    if (!rxViolReq) violDone <= 1'b0;
    idx = idx + 1;
  end
endmodule

// *** verif/line_loopback_and_test_patterns_test.sv ***
// Purpose: Self-checking bench for the line loopback and test pattern block
// Assumes: framer_line_model on the far side; Avalon-MM register access
// Notes: Mark counts span 800 cycles, about 100 line bits, so ranges allow edge slop
`timescale 1ns/1ps
module line_loopback_and_test_patterns_test
  import lb_pkg::*;
;
  localparam logic [31:0] LOC = 32'h1 << CTL_LOCAL;
  localparam logic [31:0] REM = 32'h1 << CTL_REMOTE;
  localparam logic [31:0] ANA = 32'h1 << CTL_ANALOG;
  localparam logic [31:0] NET = 32'h1 << CTL_NETDET;
  localparam logic [31:0] AOS = 32'h1 << CTL_ALLONES;
  localparam logic [31:0] JIT = 32'h1 << CTL_JITTER;
  localparam logic [31:0] PRBS = 32'(PAT_PRBS) << CTL_PATLOW;
  localparam logic [31:0] E1 = 32'h1 << CTL_E1;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, d;
  logic avs_waitrequest, transmit_clock, master_clock, recovered_clock;
  rail_s transmit_rail_inputs, line_receiver_inputs, line_driver_outputs, receive_rail_outputs, prevLd, prevRx;
  logic logic_error_insert_pin = 1'b0; // Held low: no logic errors wanted
  logic violation_insert_pin = 1'b0;
  logic line_clock_out, receive_clock_out, violation_flag_pin, jitter_in_loop, prbs_interrupt_n, prevF;
  logic clkOn = 1'b1;
  logic txMarks = 1'b0;
  logic rxViolReq = 1'b0;
  logic [4:0] rxPat = 5'h00;
  logic [2:0] rxLen = 3'h1;
  int numErrors = 0;
  int checksDone = 0;
  int lnR, rxR, viol, fR, fL, lastR, lcR, rcR;
  logic prevLc = 1'b0, prevRc = 1'b0; // Clock levels one cycle back
  int run[2];
  logic [31:0] fc[3] = '{32'h0, 32'h200, 32'h300}; // Decoder/unipolar settings
  int fe[3] = '{1, 0, 1}; // Reports expected for each
  ////////////////////////////////////////////////////////////////
  // Design and far side; short code-persistence count keeps the run brief
  line_loopback_and_test_patterns #(.LOOP_CODE_LIMIT(2000)) u_dut (.sys_clk, .reset, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .transmit_clock,
    .master_clock, .transmit_rail_inputs, .recovered_clock, .line_receiver_inputs,
    .logic_error_insert_pin, .violation_insert_pin, .line_driver_outputs, .line_clock_out,
    .receive_rail_outputs, .receive_clock_out, .violation_flag_pin, .jitter_in_loop, .prbs_interrupt_n);
  framer_line_model u_far (.clkOn, .rxOn(1'b1), .txMarks, .rxViolReq, .rxPat, .rxLen,
    .transmit_clock, .master_clock, .recovered_clock, .transmit_rail_inputs, .line_receiver_inputs);
  initial forever #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Count out of range shows the low bound as expected
  task automatic rng(input string nm, input int v, input int lo, input int hi);
    chk(nm, 32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
  endtask
  // Holds the request until waitrequest is seen low; the watchdog bounds a hang
  task automatic ack;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    chk("waitrequest", 32'(avs_waitrequest), 32'h0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    ack();
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    ack();
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // Edge counting on line and receive rails; a repeated polarity or a
  // rail held over 1.5 bits counts as a violation, whatever the duty
  task automatic meas(input int n, input logic [1:0] pulse);
    rail_s ld;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (i == 50) {rxViolReq, violation_insert_pin} <= pulse;
      if (i == 150) {rxViolReq, violation_insert_pin} <= 2'h0;
      ld = line_driver_outputs;
      for (int r = 0; r < 2; r++) begin
        if (ld[r] && !prevLd[r]) begin
          lnR++;
          if (lastR == r) viol++;
          lastR = r;
        end
        run[r] = ld[r] ? run[r] + 1 : 0;
        if (run[r] == 12) viol++;
        rxR += int'(receive_rail_outputs[r] & ~prevRx[r]);
      end
      fR += int'(violation_flag_pin & ~prevF);
      fL += int'(violation_flag_pin & prevF);
      prevLd = ld;
      prevRx = receive_rail_outputs;
      prevF = violation_flag_pin;
      lcR += int'(line_clock_out & ~prevLc);
      rcR += int'(receive_clock_out & ~prevRc);
      prevLc = line_clock_out;
      prevRc = receive_clock_out;
    end
  endtask
  // Set a mode, let it settle, then count over 800 cycles
  task automatic mode(input logic [31:0] c, input logic tm, input logic [4:0] p, input logic [2:0] l,
    input logic [1:0] pulse);
    txMarks <= tm;
    rxPat <= p;
    rxLen <= l;
    wr(OFS_CONTROL, c);
    repeat (200) @(posedge sys_clk);
    {lnR, rxR, viol, fR, fL, lastR} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, -32'sh1};
    run = '{0, 0};
    lcR = 0;
    rcR = 0;
    meas(800, pulse);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs about 40000 cycles
  initial begin
    repeat (80000) @(posedge sys_clk);
    numErrors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(OFS_CONTROL);
    chk("control reset", d, 32'(CTL_RESET));
    rd(OFS_STATUS);
    chk("status reset", d, 32'h0);
    wr(4'hC, 32'h7FF);
    rd(4'hC);
    chk("unmapped", d, 32'h0);
    wr(OFS_CONTROL, 32'h7FF);
    rd(OFS_CONTROL);
    chk("control", d, 32'h7FF);
    $display("test registers done");
    mode(LOC | JIT, 1'b1, 5'h00, 3'h1, 2'h0);
    chk("jitter_in_loop", 32'(jitter_in_loop), 32'h1);
    rng("looped marks", rxR, 95, 105);
    rng("looped clock", rcR, 95, 105);
    rng("line marks", lnR, 95, 105);
    mode(LOC | AOS, 1'b0, 5'h00, 3'h1, 2'h0);
    chk("jitter_in_loop", 32'(jitter_in_loop), 32'h0);
    rng("looped marks", rxR, 0, 0);
    rng("ones marks", lnR, 95, 105);
    clkOn <= 1'b0;
    mode(AOS, 1'b0, 5'h00, 3'h1, 2'h1);
    rng("master clock ones", lnR, 90, 105);
    rng("violations", viol, 1, 1);
    clkOn <= 1'b1;
    $display("test local and all-ones done");
    mode(REM, 1'b0, 5'h01, 3'h1, 2'h1);
    rng("remote marks", lnR, 95, 105);
    rng("recovered marks", rxR, 95, 105);
    rng("line clock", lcR, 95, 105);
    rng("violations", viol, 0, 0);
    mode(REM | AOS, 1'b1, 5'h00, 3'h1, 2'h0);
    rng("suppressed", lnR, 0, 0);
    mode(ANA | REM, 1'b1, 5'h00, 3'h1, 2'h0);
    rng("analog marks", rxR, 90, 105);
    mode(32'(PAT_UP) << CTL_PATLOW, 1'b0, 5'h00, 3'h1, 2'h0);
    rng("loop-up marks", lnR, 18, 22);
    mode(32'(PAT_DOWN) << CTL_PATLOW, 1'b0, 5'h00, 3'h1, 2'h1);
    rng("loop-down marks", lnR, 31, 36);
    rng("violations", viol, 1, 1);
    foreach (fc[i]) begin
      mode(fc[i], 1'b0, 5'h01, 3'h1, 2'h2);
      rng("reported", fR, fe[i], fe[i]);
      rng("long pulses", fL, 0, 0);
    end
    $display("test loopbacks and codes done");
    wr(OFS_CLEAR, 32'h0);
    mode(ANA | PRBS, 1'b0, 5'h00, 3'h1, 2'h0);
    meas(2000, 2'h0);
    rd(OFS_STATUS);
    chk("sync", d & 32'h3, 32'h3);
    chk("irq", 32'(prbs_interrupt_n), 32'h0);
    wr(OFS_CLEAR, 32'h2);
    rd(OFS_STATUS);
    chk("cleared", d & 32'h3, 32'h1);
    chk("irq masked", 32'(prbs_interrupt_n), 32'h1);
    // Steady ones break the recurrence; a quiet line would match it
    mode(PRBS, 1'b0, 5'h01, 3'h1, 2'h0);
    meas(2000, 2'h0);
    rd(OFS_STATUS);
    chk("sync lost", d & 32'h3, 32'h2);
    chk("irq masked", 32'(prbs_interrupt_n), 32'h1);
    wr(OFS_CLEAR, 32'h0);
    chk("irq", 32'(prbs_interrupt_n), 32'h0);
    mode(ANA | PRBS | E1, 1'b0, 5'h00, 3'h1, 2'h0);
    meas(2000, 2'h0);
    rd(OFS_STATUS);
    chk("E1 sync", 32'(d[ST_SYNC]), 32'h1);
    $display("test pattern detector done");
    mode(32'h0, 1'b0, 5'h01, 3'h5, 2'h0);
    meas(3000, 2'h0);
    rd(OFS_STATUS);
    chk("net loop off", 32'(d[ST_NETLOOP]), 32'h0);
    mode(NET, 1'b0, 5'h01, 3'h5, 2'h0);
    meas(3000, 2'h0);
    rd(OFS_STATUS);
    chk("net loop", 32'(d[ST_NETLOOP]), 32'h1);
    mode(NET | LOC, 1'b1, 5'h01, 3'h5, 2'h0);
    rng("net loop marks", lnR, 18, 22);
    rng("dual looped", rxR, 95, 105);
    mode(NET, 1'b0, 5'h01, 3'h3, 2'h0);
    meas(3000, 2'h0);
    rd(OFS_STATUS);
    chk("net loop down", 32'(d[ST_NETLOOP]), 32'h0);
    mode(NET, 1'b0, 5'h01, 3'h5, 2'h0);
    meas(3000, 2'h0);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_STATUS);
    chk("net loop disabled", 32'(d[ST_NETLOOP]), 32'h0);
    $display("test network loop done");
    close_out();
  end
endmodule
